// ===== hdl/vafe_pkg.sv
package vafe_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_SYNC_STATUS  = 8'h01;
  localparam logic [7:0] IDX_SOG_CTRL     = 8'h04;
  localparam logic [7:0] IDX_CONFIG       = 8'h05;
  localparam logic [7:0] IDX_GAIN_RED     = 8'h06;
  localparam logic [7:0] IDX_GAIN_GREEN   = 8'h07;
  localparam logic [7:0] IDX_GAIN_BLUE    = 8'h08;
  localparam logic [7:0] IDX_BW_PEAK      = 8'h0d;
  localparam logic [7:0] IDX_SYNC_SELECT  = 8'h12;
  localparam logic [7:0] IDX_EXT_CLAMP    = 8'h13;
  localparam logic [7:0] IDX_CLAMP_HI     = 8'h14;
  localparam logic [7:0] IDX_CLAMP_LO     = 8'h15;
  localparam logic [7:0] IDX_CLAMP_WIDTH  = 8'h16;
  localparam logic [7:0] IDX_OUT_FORMAT   = 8'h18;
  localparam logic [7:0] IDX_CLAMP_IMP    = 8'h23;
  localparam logic [7:0] IDX_GAIN_APPLIED = 8'h30;
  localparam int         ADDR_LSB         = 2;

  // Field positions
  localparam int CFG_DC_COUPLED   = 1;
  localparam int CFG_YUV_MODE     = 2;
  localparam int CFG_COAST_CLAMP  = 5;
  localparam int SOG_THR_MSB      = 3;
  localparam int SOG_HYST_BIT     = 4;
  localparam int SOG_LPF_BIT      = 5;
  localparam int BW_MSB           = 3;
  localparam int BW_LSB           = 1;
  localparam int PEAK_MSB         = 7;
  localparam int PEAK_LSB         = 4;
  localparam int EXT_CLAMP_BIT    = 4;
  localparam int DECIMATE_BIT     = 4;
  localparam int IMP_MSB          = 6;
  localparam int IMP_LSB          = 4;

  // Reset values
  localparam logic [7:0] RST_SOG_CTRL    = 8'h16;
  localparam logic [7:0] RST_CONFIG      = 8'h00;
  localparam logic [7:0] RST_GAIN        = 8'h55;
  localparam logic [7:0] RST_BW_PEAK     = 8'h0e;
  localparam logic [7:0] RST_CLAMP_HI    = 8'h00;
  localparam logic [7:0] RST_CLAMP_LO    = 8'h08;
  localparam logic [7:0] RST_CLAMP_WIDTH = 8'h10;
  localparam logic [7:0] RST_CLAMP_IMP   = 8'h08;

  // Levels and codes
  localparam logic [7:0] BLACK_RGB    = 8'h00;
  localparam logic [7:0] BLACK_CHROMA = 8'h80;
  localparam logic [1:0] SRC_DISCRETE = 2'h0;
  localparam logic [1:0] SRC_CSYNC_H  = 2'h1;
  localparam logic [1:0] SRC_SOG      = 2'h2;

  // Decoded corners in MHz
  localparam logic [9:0] BW_MHZ [8] = '{10'd100, 10'd130, 10'd150,
    10'd180, 10'd230, 10'd320, 10'd480, 10'd780};
  localparam logic [9:0] PEAK_MHZ [16] = '{10'd0, 10'd800, 10'd400,
    10'd265, 10'd200, 10'd160, 10'd135, 10'd115, 10'd100, 10'd90,
    10'd80, 10'd70, 10'd65, 10'd60, 10'd55, 10'd50};

  // Timing
  localparam int CLK_MHZ          = 125;
  localparam int FALLBACK_MS      = 100;
  localparam int FALLBACK_CYCLES  = FALLBACK_MS * 1000 * CLK_MHZ;
  localparam int ACTIVITY_US      = 100;
  localparam int ACTIVITY_CYCLES  = ACTIVITY_US * CLK_MHZ;
  localparam int FIFO_DEPTH       = 8;

  typedef enum logic [1:0] {
    CLAMP_IDLE,
    CLAMP_WAIT,
    CLAMP_ACTIVE
  } vafe_clamp_state_t;

endpackage : vafe_pkg

// ===== hdl/vafe_fifo.sv
`timescale 1ns/1ps
module vafe_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_N = AW'(DEPTH - 1) + 1'b1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  wire              doWrite = ce & inValid & inReady;
  wire              doRead  = ce & outValid & outReady;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign inReady  = (count != DEPTH_N);
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) wrPtr <= bump(wrPtr);
      if (doRead) rdPtr <= bump(rdPtr);
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end

  always_ff @(posedge clk) begin
    if (doWrite) mem[wrPtr] <= inData;
  end

endmodule : vafe_fifo

// ===== hdl/vafe_clamp_format_control.sv
`timescale 1ns/1ps
module vafe_clamp_format_control
  import vafe_pkg::*;
#(
  parameter int CNT_W            = 16,
  parameter int FALLBACK_CNT     = vafe_pkg::FALLBACK_CYCLES,
  parameter int ACTIVITY_CNT     = vafe_pkg::ACTIVITY_CYCLES,
  parameter int DEPTH            = vafe_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        hsyncIn,
  input  wire logic        vsyncIn,
  input  wire logic        greenEmbeddedSyncIn,
  input  wire logic        extClampIn,
  input  wire logic        pixelClockLoopCoast,
  input  wire logic        pixValid,
  output logic             pixReady,
  input  wire logic [7:0]  redIn,
  input  wire logic [7:0]  greenIn,
  input  wire logic [7:0]  blueIn,
  output logic             outValid,
  input  wire logic        outReady,
  output logic      [7:0]  redOut,
  output logic      [7:0]  greenOut,
  output logic      [7:0]  blueOut,
  output logic             clampOn,
  output logic             dcCoupled,
  output logic             yuvMode,
  output logic      [7:0]  gainRed,
  output logic      [7:0]  gainGreen,
  output logic      [7:0]  gainBlue,
  output logic      [3:0]  sogThreshold,
  output logic             sogHysteresis,
  output logic             sogLowPass,
  output logic      [9:0]  bandwidthMhz,
  output logic             peakingEnable,
  output logic      [9:0]  peakingMhz,
  output logic      [2:0]  clampImpedance
);

  import vafe_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [7:0] sogCtrl;
  logic [7:0] config0;
  logic [7:0] channel_gain_setting [3];
  logic [7:0] bwPeak;
  logic [1:0] syncSelect;
  logic [7:0] extClampCtrl;
  logic [7:0] clampStartHi;
  logic [7:0] clampStartLo;
  logic [7:0] clampWidth;
  logic [7:0] outFormat;
  logic [7:0] clampImp;
  logic [7:0] gainApplied [3];
  logic [7:0] syncStatus;
  logic       gainPending;

  wire       busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0] regIdx  = {2'h0, wb_adr_i[7:ADDR_LSB]};
  wire       wrLane0 = busReq & wb_we_i & wb_sel_i[0];
  wire [7:0] wrByte  = wb_dat_i[7:0];

  function automatic logic hit(input logic [7:0] idx);
    hit = wrLane0 & (regIdx == idx);
  endfunction : hit

  wire wrGainR = hit(IDX_GAIN_RED);
  wire wrGainG = hit(IDX_GAIN_GREEN);
  wire wrGainB = hit(IDX_GAIN_BLUE);
  wire wrGain  = wrGainR | wrGainG | wrGainB;

  logic [7:0] readByte;
  always_comb begin
    case (regIdx)
      IDX_SYNC_STATUS:  readByte = syncStatus;
      IDX_SOG_CTRL:     readByte = sogCtrl;
      IDX_CONFIG:       readByte = config0;
      IDX_GAIN_RED:     readByte = channel_gain_setting[0];
      IDX_GAIN_GREEN:   readByte = channel_gain_setting[1];
      IDX_GAIN_BLUE:    readByte = channel_gain_setting[2];
      IDX_BW_PEAK:      readByte = bwPeak;
      IDX_SYNC_SELECT:  readByte = {6'h00, syncSelect};
      IDX_EXT_CLAMP:    readByte = extClampCtrl;
      IDX_CLAMP_HI:     readByte = clampStartHi;
      IDX_CLAMP_LO:     readByte = clampStartLo;
      IDX_CLAMP_WIDTH:  readByte = clampWidth;
      IDX_OUT_FORMAT:   readByte = outFormat;
      IDX_CLAMP_IMP:    readByte = clampImp;
      IDX_GAIN_APPLIED: readByte = {7'h00, gainPending};
      default:          readByte = 8'h00;
    endcase
  end

  // Unmapped indices still acknowledge and read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= busReq;
      if (busReq) wb_dat_o <= {24'h00_0000, readByte};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sogCtrl      <= RST_SOG_CTRL;
      config0      <= RST_CONFIG;
      channel_gain_setting     <= '{RST_GAIN, RST_GAIN, RST_GAIN};
      bwPeak       <= RST_BW_PEAK;
      syncSelect   <= SRC_DISCRETE;
      extClampCtrl <= 8'h00;
      clampStartHi <= RST_CLAMP_HI;
      clampStartLo <= RST_CLAMP_LO;
      clampWidth   <= RST_CLAMP_WIDTH;
      outFormat    <= 8'h00;
      clampImp     <= RST_CLAMP_IMP;
    end else if (ce) begin
      if (hit(IDX_SOG_CTRL)) sogCtrl <= wrByte;
      if (hit(IDX_CONFIG)) config0 <= wrByte;
      if (wrGainR) channel_gain_setting[0] <= wrByte;
      if (wrGainG) channel_gain_setting[1] <= wrByte;
      if (wrGainB) channel_gain_setting[2] <= wrByte;
      if (hit(IDX_BW_PEAK)) bwPeak <= wrByte;
      if (hit(IDX_SYNC_SELECT)) syncSelect <= wrByte[1:0];
      if (hit(IDX_EXT_CLAMP)) extClampCtrl <= wrByte;
      if (hit(IDX_CLAMP_HI)) clampStartHi <= wrByte;
      if (hit(IDX_CLAMP_LO)) clampStartLo <= wrByte;
      if (hit(IDX_CLAMP_WIDTH)) clampWidth <= wrByte;
      if (hit(IDX_OUT_FORMAT)) outFormat <= wrByte;
      if (hit(IDX_CLAMP_IMP)) clampImp <= wrByte;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Analog control decode

  function automatic logic [9:0] bwDecode(input logic [2:0] code);
    bwDecode = BW_MHZ[code];
  endfunction : bwDecode

  function automatic logic [9:0] peakDecode(input logic [3:0] code);
    peakDecode = PEAK_MHZ[code];
  endfunction : peakDecode

  wire yuvSel      = config0[CFG_YUV_MODE];
  wire acCoupled   = ~config0[CFG_DC_COUPLED];
  wire coastClamp  = config0[CFG_COAST_CLAMP];
  wire decimate    = outFormat[DECIMATE_BIT];
  wire extClampSel = extClampCtrl[EXT_CLAMP_BIT];

  assign yuvMode        = yuvSel;
  assign dcCoupled      = ~acCoupled;
  assign sogThreshold   = sogCtrl[SOG_THR_MSB:0];
  assign sogHysteresis  = sogCtrl[SOG_HYST_BIT];
  assign sogLowPass     = sogCtrl[SOG_LPF_BIT];
  // Bit 0 of the register is don't-care
  assign bandwidthMhz   = bwDecode(bwPeak[BW_MSB:BW_LSB]);
  assign peakingMhz     = peakDecode(bwPeak[PEAK_MSB:PEAK_LSB]);
  assign peakingEnable  = (bwPeak[PEAK_MSB:PEAK_LSB] != 4'h0);
  assign clampImpedance = clampImp[IMP_MSB:IMP_LSB];
  // Amplifier sees the applied code only; 0x55 means unity gain
  assign gainRed        = gainApplied[0];
  assign gainGreen      = gainApplied[1];
  assign gainBlue       = gainApplied[2];

  //////////////////////////////////////////////////////////////////////////
  // Sync input conditioning and activity

  logic [3:0] syncMeta;
  logic [3:0] syncLvl;
  logic [3:0] syncPrev;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncMeta <= 4'h0;
      syncLvl  <= 4'h0;
      syncPrev <= 4'h0;
    end else if (ce) begin
      syncMeta <= {extClampIn, greenEmbeddedSyncIn, vsyncIn, hsyncIn};
      syncLvl  <= syncMeta;
      syncPrev <= syncLvl;
    end
  end

  wire [3:0] syncEdge = syncLvl ^ syncPrev;
  localparam logic [31:0] ACT_MAX = 32'(ACTIVITY_CNT);
  logic [31:0] idleCnt [3];
  logic [2:0]  active;

  // A source counts as active while edges keep arriving
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idleCnt <= '{ACT_MAX, ACT_MAX, ACT_MAX};
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (syncEdge[i]) idleCnt[i] <= 32'h0000_0000;
        else if (idleCnt[i] != ACT_MAX) idleCnt[i] <= idleCnt[i] + 1'b1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) active[i] = (idleCnt[i] != ACT_MAX);
  end

  // Composite sync on H uses the same pin as discrete H
  wire selSync  = (syncSelect == SRC_SOG) ? syncLvl[2] : syncLvl[0];
  wire selPrev  = (syncSelect == SRC_SOG) ? syncPrev[2] : syncPrev[0];
  wire trailing = selPrev & ~selSync;

  assign syncStatus = {3'h0, pixelClockLoopCoast, syncLvl[0], active[2],
                       active[1], active[0]};

  //////////////////////////////////////////////////////////////////////////
  // Clamp timing

  vafe_clamp_state_t clampState;
  vafe_clamp_state_t next_clampState;
  logic [CNT_W-1:0]  pixCount;
  logic [7:0]        widthCount;
  logic              coastSeen;

  wire [15:0] startPix  = {clampStartHi, clampStartLo};
  wire        startHit  = (pixCount == CNT_W'(startPix));
  wire        coastLine = coastSeen | pixelClockLoopCoast;
  wire        clampOk   = acCoupled & (coastClamp | ~coastLine)
                        & (clampWidth != 8'h00);
  wire        widthDone = (widthCount == clampWidth);

  always_comb begin
    next_clampState = clampState;
    case (clampState)
      CLAMP_IDLE:   next_clampState = CLAMP_IDLE;
      CLAMP_WAIT:   if (startHit) begin
        next_clampState = clampOk ? CLAMP_ACTIVE : CLAMP_IDLE;
      end
      CLAMP_ACTIVE: if (widthDone) next_clampState = CLAMP_IDLE;
      default:      next_clampState = CLAMP_IDLE;
    endcase
    if (trailing) next_clampState = CLAMP_WAIT;
  end

  // Start values past the active pixels land the clamp on the front porch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clampState <= CLAMP_IDLE;
      pixCount   <= '0;
      widthCount <= 8'h00;
      coastSeen  <= 1'b0;
    end else if (ce) begin
      clampState <= next_clampState;
      pixCount   <= trailing ? '0 : pixCount + 1'b1;
      coastSeen  <= trailing ? 1'b0 : coastLine;
      widthCount <= (next_clampState == CLAMP_ACTIVE)
                    ? widthCount + 1'b1 : 8'h00;
    end
  end

  wire intClamp   = (clampState == CLAMP_ACTIVE);
  wire intStrobe  = (clampState != CLAMP_ACTIVE)
                  & (next_clampState == CLAMP_ACTIVE);
  wire extStrobe  = syncLvl[3] & ~syncPrev[3];
  wire strobe     = extClampSel ? (extStrobe & acCoupled) : intStrobe;
  // Switching to DC coupling cuts a running clamp at once
  assign clampOn  = acCoupled & (extClampSel ? syncLvl[3] : intClamp);

  //////////////////////////////////////////////////////////////////////////
  // Gain transfer

  localparam logic [31:0] FB_MAX = 32'(FALLBACK_CNT - 1);
  logic [31:0] fallbackCnt;
  wire         fallback = gainPending & (fallbackCnt == FB_MAX);
  wire         applyNow = strobe | fallback;

  // A write in the same cycle as the transfer stays pending for the next
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gainApplied <= '{RST_GAIN, RST_GAIN, RST_GAIN};
      gainPending <= 1'b0;
      fallbackCnt <= 32'h0000_0000;
    end else if (ce) begin
      if (applyNow) gainApplied <= channel_gain_setting;
      gainPending <= wrGain | (gainPending & ~applyNow);
      if (wrGain | ~gainPending | applyNow) fallbackCnt <= 32'h0000_0000;
      else fallbackCnt <= fallbackCnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output format

  logic oddPixel;
  wire  pixTake = ce & pixValid & pixReady;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) oddPixel <= 1'b0;
    else if (ce) oddPixel <= trailing ? 1'b0 : (oddPixel ^ pixTake);
  end

  // Channels pass straight through; no matrixing between spaces
  wire [7:0] chromaBlack = yuvSel ? BLACK_CHROMA : BLACK_RGB;
  wire [7:0] redBase   = intClamp ? chromaBlack : redIn;
  wire [7:0] blueBase  = intClamp ? chromaBlack : blueIn;
  wire [7:0] greenBase = intClamp ? BLACK_RGB : greenIn;
  wire [7:0] redFmt    = decimate ? (oddPixel ? redBase : blueBase)
                                  : redBase;
  wire [7:0] blueFmt   = decimate ? 8'h00 : blueBase;

  vafe_fifo #(
    .WIDTH (24),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .inValid  (pixValid),
    .inReady  (pixReady),
    .inData   ({redFmt, greenBase, blueFmt}),
    .outValid (outValid),
    .outReady (outReady),
    .outData  ({redOut, greenOut, blueOut})
  );

endmodule : vafe_clamp_format_control

// ===== test/vafe_source_model.sv
`timescale 1ns/1ps
module vafe_source_model #(
  parameter int LINE = 160,
  parameter int SYNC = 8
) (
  input  wire logic       clk,
  input  wire logic       lines,
  input  wire logic       go,
  input  wire logic       pixReady,
  output logic            hsyncIn,
  output logic            pixValid,
  output logic      [7:0] redIn,
  output logic      [7:0] greenIn,
  output logic      [7:0] blueIn
);
  logic [7:0] pos = 8'h00;
  logic [4:0] seq = 5'h00;
  initial hsyncIn = 1'b0;
  initial pixValid = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // Idle data lines show the inverse so stale samples cannot pass as valid
  assign redIn   = {3'b010, seq} ^ {8{!pixValid}};
  assign greenIn = {3'b001, seq} ^ {8{!pixValid}};
  assign blueIn  = {3'b011, seq} ^ {8{!pixValid}};
  always @(posedge clk) begin
    pos      <= (pos == 8'(LINE - 1)) ? 8'h00 : pos + 8'h01;
    hsyncIn  <= lines && pos < 8'(SYNC);
    pixValid <= go || (pixValid && !pixReady);
    if (pixValid && pixReady)
      seq <= seq + 5'h01;
    else if (!pixValid)
      seq <= 5'h00;
  end
endmodule : vafe_source_model

// ===== test/vafe_clamp_format_control_assertions.sv
`timescale 1ns/1ps
module vafe_checker
  import vafe_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        pixelClockLoopCoast,
  input wire logic        outValid,
  input wire logic [7:0]  blueOut,
  input wire logic        clampOn,
  input wire logic        dcCoupled,
  input wire logic        yuvMode,
  input wire logic [9:0]  bandwidthMhz,
  input wire logic        peakingEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  // Shadows trail the design by a cycle; fields change on any acked write, clamp idle or not
  wire       wrDone = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o;
  wire [5:0] regIdx = wb_adr_i[7:2];
  wire [7:0] wrByte = wb_dat_i[7:0];
  wire       wrCfg  = wrDone && regIdx == IDX_CONFIG[5:0];
  wire       wrBw   = wrDone && regIdx == IDX_BW_PEAK[5:0];
  logic       decShadow;
  logic       coastShadow;
  logic [7:0] widShadow;
  logic [7:0] highCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      decShadow   <= 1'b0;
      coastShadow <= 1'b0;
      widShadow   <= RST_CLAMP_WIDTH;
      highCnt     <= 8'h00;
    end else begin
      if (wrDone && regIdx == IDX_OUT_FORMAT[5:0])
        decShadow <= wrByte[DECIMATE_BIT];
      if (wrDone && regIdx == IDX_CLAMP_WIDTH[5:0])
        widShadow <= wrByte;
      if (wrCfg)
        coastShadow <= wrByte[CFG_COAST_CLAMP];
      highCnt <= clampOn ? highCnt + 8'h01 : 8'h00;
    end
  end
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("access not acked");
  property p_yuv; wrCfg |-> yuvMode == wrByte[CFG_YUV_MODE]; endproperty
  a_yuv: assert property (p_yuv) else $error("yuv mode wrong");
  property p_blue; decShadow && outValid |-> blueOut == 8'h00; endproperty
  a_blue: assert property (p_blue) else $error("blue not low");
  property p_dc; $rose(clampOn) |-> !dcCoupled; endproperty
  a_dc: assert property (p_dc) else $error("clamp while dc");
  property p_wid; $fell(clampOn) && !dcCoupled |-> highCnt == widShadow;
  endproperty
  a_wid: assert property (p_wid) else $error("clamp width");
  property p_coast;
    $rose(clampOn) && $past(pixelClockLoopCoast) |-> coastShadow;
  endproperty
  a_coast: assert property (p_coast) else $error("clamp in coast");
  property p_bw; wrBw |-> bandwidthMhz == BW_MHZ[wrByte[BW_MSB:BW_LSB]];
  endproperty
  a_bw: assert property (p_bw) else $error("bandwidth decode");
  property p_peak;
    wrBw |-> peakingEnable == (wrByte[PEAK_MSB:PEAK_LSB] != 4'h0);
  endproperty
  a_peak: assert property (p_peak) else $error("peaking enable");
endmodule : vafe_checker

bind vafe_clamp_format_control vafe_checker chk_i (.*);

// ===== test/vafe_clamp_format_control_bench.sv
`timescale 1ns/1ps
module vafe_clamp_format_control_bench;
  import vafe_pkg::*;
  localparam int LINE = 160;
  logic        clk, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, lines, go;
  logic        hsyncIn, vsyncIn, greenEmbeddedSyncIn, extClampIn, outReady;
  logic        pixelClockLoopCoast, pixValid, pixReady, outValid, clampOn;
  logic        dcCoupled, yuvMode, sogHysteresis, sogLowPass, peakingEnable;
  logic        hsPrev, clPrev;
  logic [2:0]  clampImpedance;
  logic [3:0]  wb_sel_i, sogThreshold;
  logic [7:0]  wb_adr_i, redIn, greenIn, blueIn, redOut, greenOut, blueOut;
  logic [7:0]  gainRed, gainGreen, gainBlue, rd;
  logic [9:0]  bandwidthMhz, peakingMhz;
  logic [31:0] wb_dat_i, wb_dat_o;
  int          failures, nChecks, cyc, fallCyc, riseDly, clampLen, nClamp;
  int          d0, n0, hits;
  logic [15:0] rstRows [11] = '{16'h0416, 16'h0500, 16'h0655, 16'h0755,
    16'h0855, 16'h0d0e, 16'h1400, 16'h1508, 16'h1610, 16'h2308, 16'h3f00};
  logic [27:0] bwRows [16] = '{{8'h00, 10'd100, 10'd0},
    {8'h13, 10'd130, 10'd800}, {8'h24, 10'd150, 10'd400},
    {8'h37, 10'd180, 10'd265}, {8'h48, 10'd230, 10'd200},
    {8'h5b, 10'd320, 10'd160}, {8'h6c, 10'd480, 10'd135},
    {8'h7f, 10'd780, 10'd115}, {8'h80, 10'd100, 10'd100},
    {8'h93, 10'd130, 10'd90}, {8'ha4, 10'd150, 10'd80},
    {8'hb7, 10'd180, 10'd70}, {8'hc8, 10'd230, 10'd65},
    {8'hdb, 10'd320, 10'd60}, {8'hec, 10'd480, 10'd55},
    {8'hff, 10'd780, 10'd50}};

  vafe_clamp_format_control #(.FALLBACK_CNT(50), .ACTIVITY_CNT(200)) dut (.*);
  vafe_source_model #(.LINE(LINE)) src (.*);

  always #4 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wbAcc(input logic we, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rdat);
    int t;
    t = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {idx[5:0], 2'b00};
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    rdat = wb_dat_o[7:0];
    if (t >= 50)
      failures++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wbAcc

  // Far side stalls one cycle in three while the stream drains
  task automatic drain(input int n, input logic dec);
    logic [4:0]  c;
    logic [23:0] exp;
    int          k, t;
    k = 0;
    t = 0;
    while (k < n && t < 400) begin
      outReady <= t % 3 != 0;
      @(posedge clk);
      c = k[4:0];
      exp = {k[0] ? {3'b010, c} : {3'b011, c}, 3'b001, c, 8'h00};
      if (!dec)
        exp = {3'b010, c, 3'b001, c, 3'b011, c};
      if (outValid === 1'b1 && outReady === 1'b1) begin
        chk({redOut, greenOut, blueOut}, exp);
        k++;
      end
      t++;
    end
    outReady <= 1'b0;
    chk(k, n);
  endtask : drain

  task automatic test_done;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cyc++;
    if (hsPrev && !hsyncIn)
      fallCyc = cyc;
    if (clampOn && !clPrev) begin
      riseDly = cyc - fallCyc;
      nClamp++;
      clampLen = 0;
    end
    if (clampOn)
      clampLen++;
    hsPrev = hsyncIn;
    clPrev = clampOn;
  end

  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    test_done;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    wb_sel_i = 4'h1;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h00000000;
    {wb_cyc_i, wb_stb_i, wb_we_i, vsyncIn, greenEmbeddedSyncIn, extClampIn,
     pixelClockLoopCoast, outReady, lines, go} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wbAcc(1'b1, 8'h3f, 8'haa, rd);
    foreach (rstRows[i]) begin
      wbAcc(1'b0, rstRows[i][15:8], 8'h00, rd);
      chk(rd, rstRows[i][7:0]);
    end
    foreach (bwRows[i]) begin
      wbAcc(1'b1, IDX_BW_PEAK, bwRows[i][27:20], rd);
      wbAcc(1'b0, IDX_BW_PEAK, 8'h00, rd);
      chk({rd, bandwidthMhz, peakingMhz, peakingEnable},
          {bwRows[i], bwRows[i][9:0] != 10'd0});
    end
    wbAcc(1'b1, IDX_SOG_CTRL, 8'h2b, rd);
    chk({sogLowPass, sogHysteresis, sogThreshold}, 6'h2b);
    wbAcc(1'b1, IDX_CLAMP_IMP, 8'h58, rd);
    chk(clampImpedance, 3'h5);
    go <= 1'b1;
    repeat (20) @(posedge clk);
    chk(pixReady, 1'b0);
    go <= 1'b0;
    drain(9, 1'b0);
    repeat (3) @(posedge clk);
    chk(outValid, 1'b0);
    wbAcc(1'b1, IDX_CONFIG, 8'h04, rd);
    wbAcc(1'b1, IDX_OUT_FORMAT, 8'h10, rd);
    wbAcc(1'b1, IDX_CLAMP_WIDTH, 8'h00, rd);
    lines <= 1'b1;
    repeat (LINE) @(posedge clk);
    lines <= 1'b0;
    repeat (10) @(posedge clk);
    go <= 1'b1;
    repeat (20) @(posedge clk);
    go <= 1'b0;
    drain(9, 1'b1);
    wbAcc(1'b1, IDX_OUT_FORMAT, 8'h00, rd);
    wbAcc(1'b1, IDX_CLAMP_WIDTH, 8'h10, rd);
    lines <= 1'b1;
    go <= 1'b1;
    outReady <= 1'b1;
    repeat (2 * LINE) begin
      @(posedge clk);
      hits += outValid && {redOut, greenOut, blueOut} == 24'h800080;
    end
    go <= 1'b0;
    chk(hits != 0, 1'b1);
    while (clampOn === 1'b1) @(posedge clk);
    chk(clampLen, 16);
    d0 = riseDly;
    wbAcc(1'b1, IDX_CLAMP_LO, 8'h70, rd);
    repeat (2 * LINE) @(posedge clk);
    chk(riseDly - d0, 104);
    wbAcc(1'b1, IDX_GAIN_RED, 8'h70, rd);
    chk(gainRed, 8'h55);
    repeat (2 * LINE) @(posedge clk);
    chk(gainRed, 8'h70);
    pixelClockLoopCoast <= 1'b1;
    repeat (2) @(posedge clk);
    n0 = nClamp;
    repeat (2 * LINE) @(posedge clk);
    chk(nClamp, n0);
    wbAcc(1'b0, IDX_SYNC_STATUS, 8'h00, rd);
    chk(rd & 8'h17, 8'h11);
    wbAcc(1'b1, IDX_CONFIG, 8'h20, rd);
    repeat (2 * LINE) @(posedge clk);
    chk(nClamp > n0, 1'b1);
    pixelClockLoopCoast <= 1'b0;
    wbAcc(1'b1, IDX_CONFIG, 8'h02, rd);
    n0 = nClamp;
    repeat (2 * LINE) @(posedge clk);
    chk({nClamp == n0, dcCoupled}, 2'h3);
    lines <= 1'b0;
    repeat (LINE + 50) @(posedge clk);
    wbAcc(1'b1, IDX_GAIN_GREEN, 8'h33, rd);
    repeat (10) @(posedge clk);
    chk(gainGreen, 8'h55);
    ce <= 1'b0;
    repeat (60) @(posedge clk);
    chk(gainGreen, 8'h55);
    ce <= 1'b1;
    repeat (60) @(posedge clk);
    chk(gainGreen, 8'h33);
    wbAcc(1'b0, IDX_SYNC_STATUS, 8'h00, rd);
    chk(rd & 8'h17, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk({gainRed, gainGreen, gainBlue, dcCoupled},
        {8'h55, 8'h55, 8'h55, 1'b0});
    test_done;
  end
endmodule : vafe_clamp_format_control_bench
